// [core/hstc_timer.sv]
// Overview of operation
// - Rise nibble delays true, fall nibble complement
// - Mode field sets waveform action and pins
// - Normal mode: outputs lag waveform one cycle
// - PWM with mode 01 gives dead-timed pair
// - Other PWM modes: plain one-cycle sync
// - Reset forces compare outputs low
// - Nonzero mode overrides port, direction still rules
// - Mode 0 leaves waveform unchanged
// - New mode acts at next match
// - Force strobe acts at once, non-PWM
// - Enhanced: low bit picks signalling edge
// - Enhanced: match uses value shifted right
// - Compare words widen by one; top not
// - Enhanced keeps frequency, eleven bit resolution
// - Compare writes load at cycle end
// - Lock buffers writes; release loads whole set
// - Only PWM and slope bits shape counting
// - Normal: count zero to top, then clear
// - Normal match toggles, clears or sets
// - Overflow set as counter becomes zero
// - Toggle period is two times top plus two
// - Counter may be written any time
// - Compare flag set cycle after match
// - Dead-time prescaler divides by 1,2,4,8
// - Inversion flips pair, high in dead time
//
// The Wishbone interface to the registers and the address map were decided locally.
`include "hstc_defines.svh"
`default_nettype none
module hstc_timer #(
  parameter int CW = 10, // Counter width.
  parameter int NCH = 3  // Compare channels A, B, D.
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic [2*NCH-1:0] pin_o,
  output logic [2*NCH-1:0] pin_oe_o
);
  // ----------------------------------------
  // Register state.
  // ----------------------------------------
  logic               pwm_r;    // PWM enable.
  logic               slope_r;  // Dual-slope select.
  logic               enh_r;    // Enhanced mode enable.
  logic               lock_r;   // Update lock.
  logic               inv_r;    // Output inversion.
  logic [1:0]         dtps_r;   // Dead-time prescale.
  logic [2*NCH-1:0]   com_r;    // Mode fields.
  logic [7:0]         dt_r;     // Rise and fall nibbles.
  logic [2*NCH-1:0]   port_r;   // Port values.
  logic [2*NCH-1:0]   ddr_r;    // Port directions.
  logic               ovf_r;    // Overflow flag.
  logic [NCH-1:0]     cflag_r;  // Compare flags.
  logic [CW-1:0]      cnt_r;    // Counter value.
  logic               down_r;   // Counting down.
  logic               blk_r;    // Match blocked after write.
  logic [CW-1:0]      top_sh_r; // Written top value.
  logic [CW-1:0]      top_r;    // Active top value.
  logic [CW:0]        sh_r [NCH]; // Written compares.
  logic [CW:0]        eff_r [NCH]; // Active compares.
  logic               pend_r;   // Buffered set waiting.
  logic [2:0]         pre_r;    // Dead-time prescaler.
  logic [NCH-1:0]     match_q_r; // Match one cycle late.
  logic [NCH-1:0]     match;    // Compare equal now.

  // ----------------------------------------
  // Wishbone slave.
  // ----------------------------------------
  logic        req;   // Request present.
  logic        wr_en; // Write takes effect now.
  logic [31:0] rd_mux; // Image of addressed word.
  logic [31:0] wval;  // Image after byte lanes.
  logic [31:0] wset;  // Written ones only.
  logic        hit_ctrl, hit_stat, hit_force, hit_cnt;
  logic        hit_top, hit_dt, hit_port;
  logic [NCH-1:0] hit_cmp;

  // Merges written byte lanes over the old word.
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign req       = wb_cyc_i && wb_stb_i;
  // The write lands on the edge where the master sees ack.
  assign wr_en     = req && wb_we_i && wb_ack_o;
  assign hit_ctrl  = wb_adr_i == `HSTC_ADR_CTRL;
  assign hit_stat  = wb_adr_i == `HSTC_ADR_STAT;
  assign hit_force = wb_adr_i == `HSTC_ADR_FORCE;
  assign hit_cnt   = wb_adr_i == `HSTC_ADR_COUNT;
  assign hit_top   = wb_adr_i == `HSTC_ADR_TOP;
  assign hit_dt    = wb_adr_i == `HSTC_ADR_DT;
  assign hit_port  = wb_adr_i == `HSTC_ADR_PORT;
  assign hit_cmp   = {wb_adr_i == `HSTC_ADR_CMPD,
                      wb_adr_i == `HSTC_ADR_CMPB,
                      wb_adr_i == `HSTC_ADR_CMPA};

  // Read image; unmapped words read zero.
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux[`HSTC_B_PWM]   = pwm_r;
      rd_mux[`HSTC_B_SLOPE] = slope_r;
      rd_mux[`HSTC_B_ENH]   = enh_r;
      rd_mux[`HSTC_B_LOCK]  = lock_r;
      rd_mux[`HSTC_B_INV]   = inv_r;
      rd_mux[`HSTC_B_DTPS +: 2] = dtps_r;
      rd_mux[`HSTC_B_COM +: 2*NCH] = com_r;
    end else if (hit_stat) begin
      rd_mux[NCH:0] = {cflag_r, ovf_r};
    end else if (hit_cnt) begin
      rd_mux[CW-1:0] = cnt_r;
    end else if (hit_top) begin
      rd_mux[CW-1:0] = top_sh_r;
    end else if (hit_dt) begin
      rd_mux[7:0] = dt_r;
    end else if (hit_port) begin
      rd_mux[2*NCH-1:0] = port_r;
      rd_mux[`HSTC_B_DDR +: 2*NCH] = ddr_r;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (hit_cmp[k]) begin
          // Reads return the latest written value.
          rd_mux[CW:0] = sh_r[k];
        end
      end
    end
  end
  assign wval = merge(rd_mux, wb_dat_i, wb_sel_i);
  assign wset = merge(32'h0, wb_dat_i, wb_sel_i);

  // Ack follows the request by one cycle and drops after one.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers.
  // ----------------------------------------
  // A mode write acts on the next match, with no buffering.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_r   <= 1'b0;
      slope_r <= 1'b0;
      enh_r   <= 1'b0;
      lock_r  <= 1'b0;
      inv_r   <= 1'b0;
      dtps_r  <= 2'h0;
      com_r   <= '0;
      dt_r    <= 8'h0;
      port_r  <= '0;
      ddr_r   <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        pwm_r   <= wval[`HSTC_B_PWM];
        slope_r <= wval[`HSTC_B_SLOPE];
        enh_r   <= wval[`HSTC_B_ENH];
        lock_r  <= wval[`HSTC_B_LOCK];
        inv_r   <= wval[`HSTC_B_INV];
        dtps_r  <= wval[`HSTC_B_DTPS +: 2];
        com_r   <= wval[`HSTC_B_COM +: 2*NCH];
      end
      if (hit_dt) begin
        dt_r <= wval[7:0];
      end
      if (hit_port) begin
        port_r <= wval[2*NCH-1:0];
        ddr_r  <= wval[`HSTC_B_DDR +: 2*NCH];
      end
    end
  end

  // ----------------------------------------
  // Counter.
  // ----------------------------------------
  logic dual;    // Dual-slope PWM counting.
  logic at_top;  // Counter equals top.
  logic wrap;    // Single-slope wrap to zero.
  logic load_pt; // End of counting cycle.
  logic cnt_wr;  // Software writes the counter.
  assign dual    = pwm_r && slope_r;
  assign at_top  = cnt_r == top_r;
  assign wrap    = !dual && at_top;
  assign load_pt = wrap || (dual && down_r && cnt_r == '0);
  assign cnt_wr  = wr_en && hit_cnt;

  // A software write wins over counting at any time.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      down_r <= 1'b0;
    end else if (cnt_wr) begin
      cnt_r <= wval[CW-1:0];
    end else if (!dual) begin
      down_r <= 1'b0;
      cnt_r  <= wrap ? '0 : cnt_r + CW'(1);
    end else if (top_r == '0) begin
      cnt_r <= '0;
    end else if (!down_r) begin
      down_r <= at_top;
      cnt_r  <= at_top ? cnt_r - CW'(1) : cnt_r + CW'(1);
    end else begin
      down_r <= cnt_r != '0;
      cnt_r  <= (cnt_r == '0) ? cnt_r + CW'(1) : cnt_r - CW'(1);
    end
  end

  // Match is blocked for one cycle after a counter write.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_r <= 1'b0;
    end else begin
      blk_r <= cnt_wr;
    end
  end

  // ----------------------------------------
  // Compare buffering.
  // ----------------------------------------
  // Writes wait in the shadow set; the whole set loads at
  // cycle end unless locked, so channels never mismatch.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      top_sh_r <= `HSTC_TOP_RST;
      top_r    <= `HSTC_TOP_RST;
      pend_r   <= 1'b0;
      for (int k = 0; k < NCH; k++) begin
        sh_r[k]  <= '0;
        eff_r[k] <= '0;
      end
    end else begin
      if (load_pt && !lock_r && pend_r) begin
        top_r  <= top_sh_r;
        pend_r <= 1'b0;
        for (int k = 0; k < NCH; k++) begin
          eff_r[k] <= sh_r[k];
        end
      end
      if (wr_en && (hit_top || |hit_cmp)) begin
        pend_r <= 1'b1;
      end
      if (wr_en && hit_top) begin
        top_sh_r <= wval[CW-1:0];
      end
      for (int k = 0; k < NCH; k++) begin
        if (wr_en && hit_cmp[k]) begin
          sh_r[k] <= wval[CW:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Flags.
  // ----------------------------------------
  // Hardware set beats a same-cycle clear by software.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_r   <= 1'b0;
      cflag_r <= '0;
    end else begin
      if (wr_en && hit_stat) begin
        ovf_r   <= ovf_r & !wset[0];
        cflag_r <= cflag_r & ~wset[NCH:1];
      end
      if (!cnt_wr && (wrap || (dual && down_r && cnt_r == CW'(1)))) begin
        ovf_r <= 1'b1;
      end
      for (int k = 0; k < NCH; k++) begin
        // The flag rises on the edge that ends the match cycle.
        if (match[k]) begin
          cflag_r[k] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Dead-time prescaler.
  // ----------------------------------------
  logic [2:0] pmask; // Low bits that must be zero.
  logic       tick;  // Prescaled dead-time tick.
  assign pmask = {dtps_r == 2'h3, dtps_r[1], |dtps_r};
  assign tick  = (pre_r & pmask) == 3'h0;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  // ----------------------------------------
  // Channels.
  // ----------------------------------------
  logic [NCH-1:0]   half;  // Half-cycle accuracy bit.
  logic [NCH-1:0]   wave;  // Waveform outputs.
  logic [2*NCH-1:0] dt_o;  // Dead-time pair outputs.
  logic [NCH-1:0]   frc;   // Force strobes.
  assign frc = (wr_en && hit_force) ? wset[NCH-1:0] : '0;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      match_q_r <= '0;
    end else begin
      match_q_r <= match;
    end
  end

  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic [CW-1:0] mval; // Value used for matching.
    logic [1:0]    com;  // Mode field of this channel.
    // Enhanced mode drops the low bit from matching.
    assign mval     = enh_r ? eff_r[k][CW:1] : eff_r[k][CW-1:0];
    assign half[k]  = enh_r && eff_r[k][0];
    assign match[k] = cnt_r == mval && !blk_r;
    assign com      = com_r[2*k +: 2];

    // A set half bit moves the action to the following edge.
    hstc_wave u_wave (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .hit_i   (half[k] ? match_q_r[k] : match[k]),
      .force_i (frc[k]),
      .wrap_i  (wrap),
      .pwm_i   (pwm_r),
      .slope_i (slope_r),
      .down_i  (down_r),
      .com_i   (hstc_pkg::hstc_com_t'(com)),
      .wave_o  (wave[k])
    );

    hstc_deadtime u_dt (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .wave_i (wave[k]),
      .en_i   (pwm_r && com == 2'b01),
      .inv_i  (inv_r),
      .tick_i (tick),
      .rise_i (dt_r[7:4]),
      .fall_i (dt_r[3:0]),
      .true_o (dt_o[2*k]),
      .comp_o (dt_o[2*k+1])
    );

    // Port override; the pin drives only when set as output.
    assign pin_o[2*k]      = (com != 2'b00) ? dt_o[2*k] : port_r[2*k];
    assign pin_o[2*k+1]    = (com != 2'b00) ? dt_o[2*k+1] : port_r[2*k+1];
    assign pin_oe_o[2*k+1 -: 2] = ddr_r[2*k+1 -: 2];

    a_pin_override : assert property (@(posedge mclk_i) disable iff (rst_i)
      (com != 2'b00) |-> (pin_o[2*k] == dt_o[2*k]))
      else $error("port not overridden");
    a_flag_late : assert property (@(posedge mclk_i) disable iff (rst_i)
      match[k] |=> cflag_r[k])
      else $error("compare flag late");
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  a_ovf_at_zero : assert property (@(posedge mclk_i) disable iff (rst_i)
    (wrap && !cnt_wr) |=> (cnt_r == '0 && ovf_r))
    else $error("overflow not set at zero");
  a_lock_holds : assert property (@(posedge mclk_i) disable iff (rst_i)
    lock_r |=> ($stable(top_r) && $stable(eff_r[0])))
    else $error("locked set loaded");
  a_ack_single : assert property (@(posedge mclk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  c_overflow : cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(ovf_r));
  c_lock_release : cover property (@(posedge mclk_i) disable iff (rst_i)
    $fell(lock_r) ##[1:1000] $fell(pend_r));
endmodule // hstc_timer
`default_nettype wire

// [core/hstc_defines.svh]
`ifndef HSTC_DEFINES_SVH
`define HSTC_DEFINES_SVH
// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define HSTC_ADR_CTRL  8'h00
`define HSTC_ADR_STAT  8'h04
`define HSTC_ADR_FORCE 8'h08
`define HSTC_ADR_COUNT 8'h0c
`define HSTC_ADR_TOP   8'h10
`define HSTC_ADR_CMPA  8'h14
`define HSTC_ADR_CMPB  8'h18
`define HSTC_ADR_CMPD  8'h1c
`define HSTC_ADR_DT    8'h20
`define HSTC_ADR_PORT  8'h24
// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define HSTC_B_PWM   0
`define HSTC_B_SLOPE 1
`define HSTC_B_ENH   2
`define HSTC_B_LOCK  3
`define HSTC_B_INV   4
`define HSTC_B_DTPS  5
`define HSTC_B_COM   8
`define HSTC_B_DDR   8
`define HSTC_TOP_RST 10'h3ff
`endif

// [core/hstc_pkg.sv]
`default_nettype none
// ----------------------------------------
// Shared types.
// ----------------------------------------
package hstc_pkg;
  // Compare output mode encodings.
  typedef enum logic [1:0] {
    HSTC_COM_OFF = 2'b00,
    HSTC_COM_TOG = 2'b01,
    HSTC_COM_CLR = 2'b10,
    HSTC_COM_SET = 2'b11
  } hstc_com_t;
endpackage
`default_nettype wire

// [core/hstc_wave.sv]
`default_nettype none
// ----------------------------------------
// Waveform output of one channel.
// ----------------------------------------
module hstc_wave (
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  input  wire logic            hit_i,
  input  wire logic            force_i,
  input  wire logic            wrap_i,
  input  wire logic            pwm_i,
  input  wire logic            slope_i,
  input  wire logic            down_i,
  input  wire hstc_pkg::hstc_com_t com_i,
  output logic                 wave_o
);
  // Next level of the waveform.
  logic wave_nxt;
  always_comb begin
    wave_nxt = wave_o;
    if (com_i == hstc_pkg::HSTC_COM_OFF) begin
      wave_nxt = wave_o;
    end else if (!pwm_i) begin
      if (hit_i || force_i) begin
        case (com_i)
          hstc_pkg::HSTC_COM_TOG: wave_nxt = !wave_o;
          hstc_pkg::HSTC_COM_CLR: wave_nxt = 1'b0;
          default:                wave_nxt = 1'b1;
        endcase
      end
    end else if (slope_i) begin
      // Dual slope: direction picks the level.
      if (hit_i) begin
        wave_nxt = (com_i == hstc_pkg::HSTC_COM_SET) ^ down_i;
      end
    end else if (hit_i) begin
      wave_nxt = (com_i == hstc_pkg::HSTC_COM_SET);
    end else if (wrap_i) begin
      wave_nxt = (com_i != hstc_pkg::HSTC_COM_SET);
    end
  end
  // Level changes on the edge of the event.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_o <= 1'b0;
    end else begin
      wave_o <= wave_nxt;
    end
  end
  a_mode_off_hold : assert property (@(posedge mclk_i) disable iff (rst_i)
    (com_i == hstc_pkg::HSTC_COM_OFF) |=> $stable(wave_o))
    else $error("wave moved with mode off");
  a_toggle_on_hit : assert property (@(posedge mclk_i) disable iff (rst_i)
    (!pwm_i && com_i == hstc_pkg::HSTC_COM_TOG && (hit_i || force_i))
    |=> (wave_o != $past(wave_o)))
    else $error("toggle missed");
endmodule // hstc_wave
`default_nettype wire

// [core/hstc_deadtime.sv]
`default_nettype none
// ----------------------------------------
// Dead-time pair generator of one channel.
// ----------------------------------------
module hstc_deadtime (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       wave_i,
  input  wire logic       en_i,
  input  wire logic       inv_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] rise_i,
  input  wire logic [3:0] fall_i,
  output logic            true_o,
  output logic            comp_o
);
  logic [3:0] cnt_r;  // Dead-time down counter.
  logic       prev_r; // Previous waveform level.
  logic [3:0] nib;    // Nibble for this edge.
  logic       edge_s; // Waveform edge seen.
  assign edge_s = wave_i != prev_r;
  assign nib    = wave_i ? rise_i : fall_i;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= wave_i;
    end
  end
  // Both outputs rest at the idle level while counting.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 4'h0;
      true_o <= 1'b0;
      comp_o <= 1'b0;
    end else if (!en_i) begin
      cnt_r  <= 4'h0;
      true_o <= wave_i;
      comp_o <= !wave_i;
    end else if (edge_s && nib != 4'h0) begin
      cnt_r  <= nib;
      true_o <= inv_i;
      comp_o <= inv_i;
    end else if (cnt_r != 4'h0) begin
      if (tick_i) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end else begin
      true_o <= wave_i ^ inv_i;
      comp_o <= !wave_i ^ inv_i;
    end
  end
  a_sync_follow : assert property (@(posedge mclk_i) disable iff (rst_i)
    !en_i |=> (true_o == $past(wave_i)))
    else $error("sync delay broken");
  a_dead_idle : assert property (@(posedge mclk_i) disable iff (rst_i)
    (en_i && edge_s && nib != 4'h0) |=> (true_o == comp_o))
    else $error("pair overlaps in dead time");
  c_dead_run : cover property (@(posedge mclk_i) disable iff (rst_i)
    en_i && cnt_r != 4'h0 ##1 cnt_r == 4'h0);
endmodule // hstc_deadtime
`default_nettype wire

// [verification/hstc_switch_model.sv]
`default_nettype none
// ----------------------------------------
// Power switch stand-in on the channel A pins.
// ----------------------------------------
module hstc_switch_model (
  input  wire logic       mclk_i,   // Timer clock.
  input  wire logic       rst_i,    // Async reset, active high.
  input  wire logic [5:0] pin_i,    // Pin levels.
  input  wire logic [5:0] oe_i,     // Pin enables.
  output int              rises_o,  // Rising edges seen on the true A pin.
  output int              period_o  // Cycles between the last two rises.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_r;  // Driven level of true A at the last edge.
  int   age_r;   // Cycles since the last rise.
  // A gate driver only sees a level while the pin is enabled, so an
  // undriven pin counts as low and cannot fake an edge.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r   <= 1'b0;
      age_r    <= 0;
      rises_o  <= 0;
      period_o <= 0;
    end else begin
      prev_r <= pin_i[0] & oe_i[0];
      age_r  <= age_r + 1;
      if ((pin_i[0] & oe_i[0] & ~prev_r) === 1'b1) begin
        rises_o  <= rises_o + 1;
        period_o <= age_r + 1;
        age_r    <= 0;
      end
    end
  end
endmodule // hstc_switch_model
`default_nettype wire

// [verification/hstc_timer_tb.sv]
`include "hstc_defines.svh"
`default_nettype none
module hstc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;  // Timer clock, 25 ns.
  logic        rst_i  = 1'b1;  // Reset.
  logic        cyc    = 1'b0;  // Bus request.
  logic        stb    = 1'b0;  // Bus strobe.
  logic        we     = 1'b0;  // Bus direction.
  logic [7:0]  adr    = 8'h00; // Bus address.
  logic [31:0] wdat   = 32'h0; // Write data.
  logic [31:0] wb_dat_o;       // Read data.
  logic        wb_ack_o;       // Bus answer.
  logic [5:0]  pin_o;          // Pin levels.
  logic [5:0]  pin_oe_o;       // Pin enables.
  int          rises;          // Rises seen by the switch model.
  int          period;         // Last period seen by the switch model.
  int          fails   = 0;    // Mismatches.
  int          checked = 0;    // Comparisons.
  logic [31:0] seed    = 32'h2375;
  logic [31:0] rd;
  int          top;
  int          n;
  int          same;           // Cycles with both pair pins equal.
  int          bad;            // Equal cycles at the wrong level.
  logic [1:0]  modes [3] = '{2'b11, 2'b10, 2'b01};
  logic        lvls  [3] = '{1'b1, 1'b0, 1'b1};

  always #12.5 mclk_i = ~mclk_i;

  hstc_timer #(.CW(10), .NCH(3)) u_hstc_timer (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o)
  );
  hstc_switch_model u_hstc_switch_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .pin_i(pin_o), .oe_i(pin_oe_o),
    .rises_o(rises), .period_o(period)
  );

  // Galois-free shift register, so the run repeats exactly every time.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One classic cycle; signals move only right after an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    if (k >= 50) begin
      fails++;
      $display("unexpected bus timeout at %h", a);
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits for three more rises on true A; a stall ends the run.
  task automatic wait_rises();
    int base;
    base = rises;
    for (int k = 0; k < 3000 && rises < base + 3; k++) @(posedge mclk_i);
    if (rises < base + 3) begin
      fails++;
      $display("unexpected rises expected %0d seen %0d", base + 3, rises);
      print_verdict();
    end
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset state and an unmapped place.
    chk("pins", 32'h0, {26'h0, pin_o});
    wb(1'b0, `HSTC_ADR_TOP, 32'h0);
    chk("top", 32'h3ff, rd);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // Port value shows while every channel mode is off.
    wb(1'b1, `HSTC_ADR_PORT, 32'h3f2a);
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk("port pins", 32'h2a, {26'h0, pin_o});
    chk("port oe", 32'h3f, {26'h0, pin_oe_o});
    $display("test port done");
    // Normal toggle: period follows the random top value.
    seed = lfsr(seed);
    top  = 4 + int'(seed[2:0]);
    wb(1'b1, `HSTC_ADR_TOP, 32'(top));
    wb(1'b1, `HSTC_ADR_CMPA, {29'h0, seed[5:3]} % 32'(top));
    wb(1'b1, `HSTC_ADR_CTRL, 32'h100);
    wait_rises();
    chk("period", 32'(2 * (top + 1)), 32'(period));
    // Flags cleared by writing ones, then set again by counting.
    wb(1'b1, `HSTC_ADR_STAT, 32'hf);
    rd = 32'h0;
    for (int k = 0; k < 40 && rd[1:0] !== 2'b11; k++) wb(1'b0, `HSTC_ADR_STAT, 32'h0);
    chk("flags", 32'h3, {30'h0, rd[1:0]});
    $display("test toggle done");
    // Forced action with a compare value the counter never reaches.
    wb(1'b1, `HSTC_ADR_CMPA, 32'h7ff);
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, `HSTC_ADR_CTRL, {22'h0, modes[m], 8'h00});
      wb(1'b1, `HSTC_ADR_FORCE, 32'h1);
      for (int k = 0; k < 10 && pin_o[0] !== lvls[m]; k++) @(posedge mclk_i);
      chk("forced", {31'h0, lvls[m]}, {31'h0, pin_o[0]});
    end
    $display("test force done");
    // Locked compare writes stay buffered; the release loads them.
    wb(1'b1, `HSTC_ADR_CTRL, 32'h108);
    wb(1'b1, `HSTC_ADR_CMPA, 32'h4);
    n = rises;
    repeat (40) @(posedge mclk_i);
    chk("locked rises", 32'(n), 32'(rises));
    wb(1'b1, `HSTC_ADR_CTRL, 32'h100);
    wait_rises();
    chk("released period", 32'(2 * (top + 1)), 32'(period));
    $display("test lock done");
    // Complementary pair in fast PWM: equal pins only at the idle level.
    wb(1'b1, `HSTC_ADR_DT, 32'h11);
    for (int v = 0; v < 2; v++) begin
      wb(1'b1, `HSTC_ADR_CTRL, 32'h101 | (32'(v) << `HSTC_B_INV));
      repeat (16) @(posedge mclk_i);
      same = 0;
      bad  = 0;
      for (int k = 0; k < 64; k++) begin
        @(posedge mclk_i);
        if (pin_o[0] === pin_o[1]) same++;
        if (pin_o[0] === pin_o[1] && pin_o[0] !== v[0]) bad++;
      end
      chk("pair overlap", 32'h0, 32'(bad));
      chk("dead time seen", 32'h1, {31'h0, same > 0});
    end
    $display("test deadtime done");
    print_verdict();
  end
endmodule // hstc_timer_tb
`default_nettype wire
